// ===== scs_defs.vh
// Constants for the supply companion control logic
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

`define SCS_CLK_MHZ       100
`define SCS_NREQ_MS       350
`define SCS_INT_PULSE_US  10
`define SCS_RST_DUR_US    1000
`define SCS_WD_P0_MS      10
`define SCS_WD_P1_MS      50
`define SCS_WD_P2_MS      150
`define SCS_WD_P3_MS      350
`define SCS_HS_PER_MS     20
`define SCS_HS_ON_US      200

// Register indices; byte address is four times the index
`define SCS_IDX_MODE      3'h0
`define SCS_IDX_WDOG      3'h1
`define SCS_IDX_IRQ_EN    3'h2
`define SCS_IDX_IRQ       3'h3
`define SCS_IDX_IO        3'h4
`define SCS_IDX_MAIN      3'h5

// Operating modes
`define SCS_M_RESET       3'h0
`define SCS_M_NREQ        3'h1
`define SCS_M_NORMAL      3'h2
`define SCS_M_STANDBY     3'h3
`define SCS_M_STOP        3'h4
`define SCS_M_SLEEP       3'h5

// Interrupt flag positions, and the battery-fail bit position in the IO status register
`define SCS_IRQ_SUPLOW    0
`define SCS_IRQ_TEMP      1
`define SCS_IRQ_HSOT_V2   2
`define SCS_IO_BATTERY_FAIL_FLAG    3

`define SCS_RST_MODE_CMD  3'h2
`define SCS_RST_WD_CFG    3'h4
`define SCS_SYNC_INIT     16'h000c

`endif

// ===== scs_sync.v
// Two-flop synchroniser bank for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module scs_sync #(
  parameter         W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         aclk,    // System clock
  input  wire         aresetn, // Synchronous reset, active low
  input  wire         ce,      // Clock enable
  input  wire [W-1:0] d,       // Asynchronous inputs
  output reg  [W-1:0] sync_q   // Synchronised outputs
);
  reg [W-1:0] meta_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== scs_ctrl.v
// Supply companion control logic: serial port, CAN pins, modes, flags, AXI4-Lite registers
// Operation
// - Sample MOSI on each falling SCLK edge.
// - Change MISO on rising SCLK edge for master sampling next falling.
// - Serial port selected only while chip select is low.
// - Drive CAN dominant when transmit input low, recessive when high.
// - Receive output low on dominant bus, high on recessive.
// - Reset output low in reset mode, high otherwise.
// - Main regulator undervoltage forces reset output low.
// - Outside Stop, an enabled active interrupt source holds interrupt low until cleared.
// - Only enabled sources reach the interrupt output.
// - In Stop, wake-up gives one 10 us low interrupt pulse.
// - Watchdog output low when watchdog not serviced correctly.
// - Level inputs readable, and wake sources in Sleep and Stop.
// - Battery-fail bit set in every mode on low battery.
// - Low-supply warning and maskable interrupt only in Normal and Standby.
// - Temperature pre-warning flag in main control and interrupt registers.
// - Regulator switched off above shutdown temperature.
// - Secondary-supply-low bit set while secondary supply is low.
// - Switch overtemperature sets status flag and combined interrupt flag.
// - Switch from register; cyclic in Sleep/Stop, steady in Normal/Standby.
// - Accurate oscillator for active modes, low-accuracy one for Sleep/Stop.
// - Four primary modes, selected only by commands; the code also re-enters Sleep on Normal Request expiry after a Sleep wake-up.
// - Normal Request entered automatically after reset and Stop wake-up.
// - Normal Request timer; watchdog configuration before expiry moves on.
// - Reset mode holds reset for a timed duration, then Normal Request.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.vh"
module scs_ctrl #(
  parameter NREQ_CYC = `SCS_NREQ_MS * 1000 * `SCS_CLK_MHZ,
  parameter RST_CYC  = `SCS_RST_DUR_US * `SCS_CLK_MHZ,
  parameter WD_P0    = `SCS_WD_P0_MS * 1000 * `SCS_CLK_MHZ,
  parameter WD_P1    = `SCS_WD_P1_MS * 1000 * `SCS_CLK_MHZ,
  parameter WD_P2    = `SCS_WD_P2_MS * 1000 * `SCS_CLK_MHZ,
  parameter WD_P3    = `SCS_WD_P3_MS * 1000 * `SCS_CLK_MHZ,
  parameter HS_PER   = `SCS_HS_PER_MS * 1000 * `SCS_CLK_MHZ,
  parameter HS_ON    = `SCS_HS_ON_US * `SCS_CLK_MHZ
) (
  input  wire        aclk,                    // System clock, 100 MHz
  input  wire        aresetn,                 // Synchronous reset, active low
  input  wire        ce,                      // Clock enable, freezes state when low
  input  wire [11:0] awaddr,                  // AXI write address
  input  wire        awvalid,                 // AXI write address valid
  output reg         awready,                 // AXI write address ready
  input  wire [31:0] wdata,                   // AXI write data
  input  wire [3:0]  wstrb,                   // AXI write strobes
  input  wire        wvalid,                  // AXI write data valid
  output reg         wready,                  // AXI write data ready
  output reg  [1:0]  bresp,                   // AXI write response
  output reg         bvalid,                  // AXI write response valid
  input  wire        bready,                  // AXI write response ready
  input  wire [11:0] araddr,                  // AXI read address
  input  wire        arvalid,                 // AXI read address valid
  output reg         arready,                 // AXI read address ready
  output reg  [31:0] rdata,                   // AXI read data
  output reg  [1:0]  rresp,                   // AXI read response
  output reg         rvalid,                  // AXI read data valid
  input  wire        rready,                  // AXI read data ready
  input  wire        spi_sclk,                // Serial clock pin
  input  wire        spi_mosi,                // Serial data in pin
  input  wire        spi_cs_n,                // Serial chip select pin, active low
  output reg         spi_miso,                // Serial data out
  output reg         spi_miso_oe,             // Serial data out enable
  input  wire        can_txd,                 // Transmit input from protocol controller
  input  wire        can_bus_dom,             // Bus receiver sees dominant
  output reg         can_drive_dom,           // Drive bus dominant
  output reg         can_rxd,                 // Receive output to protocol controller
  input  wire        mon_bat_low,             // Battery below fail threshold
  input  wire        mon_sup_warn,            // Battery below early warning threshold
  input  wire        mon_sec_low,             // Secondary supply low
  input  wire        mon_main_uv,             // Main regulator under reset threshold
  input  wire        mon_temp_warn,           // Main regulator temperature warning
  input  wire        mon_temp_sd,             // Main regulator temperature shutdown
  input  wire        mon_hs_ot,               // High-side switch overtemperature
  input  wire [3:0]  level_wake_inputs,       // Level inputs
  output reg         rst_out_n,               // Reset output, active low
  output reg         int_n,                   // Interrupt output, active low
  output reg         watchdog_fault_output_n, // Watchdog fault, active low
  output reg         high_side_switch,        // High-side switch on
  output reg         main_regulator_off,      // Main regulator shut off
  output reg         osc_low_sel              // Low-accuracy oscillator selected
);
  localparam INT_CYC = `SCS_INT_PULSE_US * `SCS_CLK_MHZ;

  wire [15:0] s;
  scs_sync #(.W(16), .INIT(`SCS_SYNC_INIT)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({level_wake_inputs, mon_hs_ot, mon_temp_sd, mon_temp_warn, mon_main_uv,
               mon_sec_low, mon_sup_warn, mon_bat_low, can_bus_dom, can_txd,
               spi_cs_n, spi_mosi, spi_sclk}),
    .sync_q  (s)
  );
  wire       s_sclk = s[0];
  wire       s_mosi = s[1];
  wire       s_cs_n = s[2];
  wire       s_txd  = s[3];
  wire       s_dom  = s[4];
  wire       s_bat  = s[5];
  wire       s_warn = s[6];
  wire       s_sec  = s[7];
  wire       s_uv   = s[8];
  wire       s_tw   = s[9];
  wire       s_tsd  = s[10];
  wire       s_hsot = s[11];
  wire [3:0] s_lvl  = s[15:12];

  reg        sclk_prev_q;
  reg        cs_prev_q;
  reg [15:0] rx_sr_q;
  reg [15:0] tx_sr_q;
  reg [4:0]  bit_cnt_q;
  reg [2:0]  mode_q;
  reg [2:0]  mode_cmd_q;
  reg [2:0]  wd_cfg_q;
  reg [2:0]  irq_en_q;
  reg [2:0]  irq_q;
  reg        bat_fail_q;
  reg [1:0]  hs_ctl_q;
  reg        from_sleep_q;
  reg [31:0] tmr_q;
  reg [31:0] wd_cnt_q;
  reg [31:0] pulse_q;
  reg [3:0]  lvl_ref_q;
  reg        wd_flt_q;
  reg [2:0]  aw_idx_q;
  reg        aw_ok_q;
  reg [7:0]  w_dat_q;
  reg        w_lane_q;

  wire sclk_rise = s_sclk & ~sclk_prev_q;
  wire sclk_fall = ~s_sclk & sclk_prev_q;
  wire cs_fall   = ~s_cs_n & cs_prev_q;
  wire cs_rise   = s_cs_n & ~cs_prev_q;

  wire act_mode  = (mode_q == `SCS_M_NORMAL) || (mode_q == `SCS_M_STANDBY);
  wire low_mode  = (mode_q == `SCS_M_STOP) || (mode_q == `SCS_M_SLEEP);
  wire sup_low   = s_warn & act_mode;
  wire [7:0] io_stat = {s_lvl, bat_fail_q, s_hsot, s_sec, sup_low};
  wire [7:0] main_stat = {3'b000, main_regulator_off, irq_q[`SCS_IRQ_TEMP], mode_q};

  // A frame counts only when exactly 16 bits arrived; writes land at the end of the frame
  wire       spi_wr = cs_rise & (bit_cnt_q == 5'd16) & rx_sr_q[15];
  wire       ax_wr  = ~awready & ~wready & ~bvalid & ~spi_wr;
  wire       wr_en  = spi_wr | (ax_wr & aw_ok_q & w_lane_q);
  wire [2:0] wr_idx = spi_wr ? rx_sr_q[14:12] : aw_idx_q;
  wire [7:0] wr_dat = spi_wr ? rx_sr_q[7:0] : w_dat_q;
  wire       mode_req = wr_en & (wr_idx == `SCS_IDX_MODE);
  wire       wd_touch = wr_en & (wr_idx == `SCS_IDX_WDOG);

  wire [2:0] irq_set;
  assign irq_set[`SCS_IRQ_SUPLOW]  = sup_low;
  assign irq_set[`SCS_IRQ_TEMP]    = s_tw;
  assign irq_set[`SCS_IRQ_HSOT_V2] = s_hsot | s_sec;
  wire [2:0] irq_clr = (wr_en && wr_idx == `SCS_IDX_IRQ) ? wr_dat[2:0] : 3'b000;
  wire       bat_clr = wr_en && (wr_idx == `SCS_IDX_IO) && wr_dat[`SCS_IO_BATTERY_FAIL_FLAG];

  reg [31:0] wd_per;
  always @* begin
    case (wd_cfg_q[1:0])
      2'b00:   wd_per = WD_P0;
      2'b01:   wd_per = WD_P1;
      2'b10:   wd_per = WD_P2;
      default: wd_per = WD_P3;
    endcase
  end
  // Window mode: a service in the first half of the period is as bad as none at all
  wire wd_bad = (wd_cnt_q >= wd_per - 1) ||
                (wd_touch && wd_cfg_q[2] && (wd_cnt_q < (wd_per >> 1)));
  wire wake = (s_lvl != lvl_ref_q);

  function [7:0] reg_rd;
    input [2:0] idx;
    begin
      case (idx)
        `SCS_IDX_MODE:   reg_rd = {5'b00000, mode_cmd_q};
        `SCS_IDX_WDOG:   reg_rd = {5'b00000, wd_cfg_q};
        `SCS_IDX_IRQ_EN: reg_rd = {5'b00000, irq_en_q};
        `SCS_IDX_IRQ:    reg_rd = {5'b00000, irq_q};
        `SCS_IDX_IO:     reg_rd = io_stat;
        `SCS_IDX_MAIN:   reg_rd = main_stat;
        default:         reg_rd = 8'h00;
      endcase
    end
  endfunction
  wire ar_ok = (araddr[11:5] == 7'h00) && (araddr[4:2] <= `SCS_IDX_MAIN);
  wire aw_ok = (awaddr[11:5] == 7'h00) && (awaddr[4:2] <= `SCS_IDX_MAIN);

  // Serial port, oversampled by aclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
      rx_sr_q     <= 16'h0000;
      tx_sr_q     <= 16'h0000;
      bit_cnt_q   <= 5'd0;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (ce) begin
      sclk_prev_q <= s_sclk;
      cs_prev_q   <= s_cs_n;
      spi_miso    <= tx_sr_q[15];
      spi_miso_oe <= ~s_cs_n;
      if (cs_fall) begin
        tx_sr_q   <= {io_stat, 1'b0, irq_q, 1'b0, mode_q};
        bit_cnt_q <= 5'd0;
      end else if (!s_cs_n) begin
        if (sclk_fall) begin
          rx_sr_q <= {rx_sr_q[14:0], s_mosi};
          if (bit_cnt_q != 5'd31)
            bit_cnt_q <= bit_cnt_q + 5'd1;
        end
        // First bit is presented at select, so the first rising edge must not shift
        if (sclk_rise && bit_cnt_q != 5'd0)
          tx_sr_q <= {tx_sr_q[14:0], 1'b0};
      end
    end
  end

  // Registers written from either port; a same-cycle serial write goes first, the AXI write lands one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_cmd_q <= `SCS_RST_MODE_CMD;
      wd_cfg_q   <= `SCS_RST_WD_CFG;
      irq_en_q   <= 3'b000;
      irq_q      <= 3'b000;
      bat_fail_q <= 1'b0;
      hs_ctl_q   <= 2'b00;
    end else if (ce) begin
      if (mode_req)
        mode_cmd_q <= wr_dat[2:0];
      if (wd_touch)
        wd_cfg_q <= wr_dat[2:0];
      if (wr_en && wr_idx == `SCS_IDX_IRQ_EN)
        irq_en_q <= wr_dat[2:0];
      if (wr_en && wr_idx == `SCS_IDX_MAIN)
        hs_ctl_q <= wr_dat[1:0];
      irq_q      <= (irq_q & ~irq_clr) | irq_set;
      bat_fail_q <= (bat_fail_q & ~bat_clr) | s_bat;
    end
  end

  // Mode sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_q       <= `SCS_M_RESET;
      tmr_q        <= 32'd0;
      wd_cnt_q     <= 32'd0;
      pulse_q      <= 32'd0;
      from_sleep_q <= 1'b0;
      wd_flt_q     <= 1'b0;
      lvl_ref_q    <= 4'h0;
    end else if (ce) begin
      tmr_q <= tmr_q + 32'd1;
      if (pulse_q != 32'd0)
        pulse_q <= pulse_q - 32'd1;
      if (!low_mode)
        lvl_ref_q <= s_lvl;
      if (act_mode)
        wd_cnt_q <= wd_touch ? 32'd0 : wd_cnt_q + 32'd1;
      else if (low_mode)
        wd_cnt_q <= (wd_cnt_q >= HS_PER - 1) ? 32'd0 : wd_cnt_q + 32'd1;
      else
        wd_cnt_q <= 32'd0;
      if (s_uv) begin
        mode_q <= `SCS_M_RESET;
        tmr_q  <= 32'd0;
      end else begin
        case (mode_q)
          `SCS_M_RESET: begin
            if (tmr_q >= RST_CYC - 1) begin
              mode_q   <= `SCS_M_NREQ;
              tmr_q    <= 32'd0;
              wd_flt_q <= 1'b0;
            end
          end
          `SCS_M_NREQ: begin
            if (wd_touch) begin
              mode_q   <= (mode_cmd_q == `SCS_M_STANDBY) ? `SCS_M_STANDBY : `SCS_M_NORMAL;
              wd_cnt_q <= 32'd0;
            end else if (tmr_q >= NREQ_CYC - 1) begin
              mode_q <= from_sleep_q ? `SCS_M_SLEEP : `SCS_M_RESET;
              tmr_q  <= 32'd0;
            end
          end
          `SCS_M_NORMAL, `SCS_M_STANDBY: begin
            if (wd_bad) begin
              mode_q       <= `SCS_M_RESET;
              tmr_q        <= 32'd0;
              wd_flt_q     <= 1'b1;
              from_sleep_q <= 1'b0;
            end else if (mode_req) begin
              case (wr_dat[2:0])
                `SCS_M_NORMAL, `SCS_M_STANDBY, `SCS_M_STOP: begin
                  mode_q   <= wr_dat[2:0];
                  wd_cnt_q <= 32'd0;
                end
                `SCS_M_SLEEP: begin
                  mode_q   <= `SCS_M_SLEEP;
                  wd_cnt_q <= 32'd0;
                end
                default: begin
                  mode_q <= mode_q;
                end
              endcase
            end
          end
          `SCS_M_STOP: begin
            // Level change or a chip-select release wakes straight to Normal Request
            if (wake || cs_rise) begin
              mode_q       <= `SCS_M_NREQ;
              tmr_q        <= 32'd0;
              from_sleep_q <= 1'b0;
              pulse_q      <= INT_CYC;
            end
          end
          `SCS_M_SLEEP: begin
            if (wake) begin
              mode_q       <= `SCS_M_RESET;
              tmr_q        <= 32'd0;
              from_sleep_q <= 1'b1;
            end
          end
          default: begin
            mode_q <= `SCS_M_RESET;
          end
        endcase
      end
    end
  end

  // Pin outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_out_n               <= 1'b0;
      int_n                   <= 1'b1;
      watchdog_fault_output_n <= 1'b1;
      high_side_switch        <= 1'b0;
      main_regulator_off      <= 1'b0;
      osc_low_sel             <= 1'b0;
      can_drive_dom           <= 1'b0;
      can_rxd                 <= 1'b1;
    end else if (ce) begin
      rst_out_n <= (mode_q != `SCS_M_RESET) & ~s_uv;
      // In Stop only the wake pulse reaches the pin, never the held level
      int_n <= ~((pulse_q != 32'd0) ||
                 ((mode_q != `SCS_M_STOP) && |(irq_q & irq_en_q)));
      watchdog_fault_output_n <= ~wd_flt_q;
      high_side_switch <= ~s_hsot & (act_mode ? hs_ctl_q[0] :
                          (low_mode & hs_ctl_q[1] & (wd_cnt_q < HS_ON)));
      main_regulator_off <= s_tsd;
      osc_low_sel        <= low_mode;
      can_drive_dom      <= ~s_txd;
      can_rxd            <= ~s_dom;
    end
  end

  // AXI4-Lite slave; one write and one read in flight, address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= 2'b00;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rresp    <= 2'b00;
      rdata    <= 32'h0000_0000;
      aw_idx_q <= 3'h0;
      aw_ok_q  <= 1'b0;
      w_dat_q  <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready  <= 1'b0;
        aw_idx_q <= awaddr[4:2];
        aw_ok_q  <= aw_ok;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_dat_q  <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      if (ax_wr) begin
        bvalid <= 1'b1;
        bresp  <= aw_ok_q ? 2'b00 : 2'b10;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= ar_ok ? 2'b00 : 2'b10;
        rdata   <= {24'h00_0000, ar_ok ? reg_rd(araddr[4:2]) : 8'h00};
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== scs_ctrl_assertions.sv
// Pin-level checker for the supply companion control logic
`timescale 1ns/1ps
`default_nettype none
module scs_ctrl_assertions (
  input wire logic aclk,              // Clock
  input wire logic aresetn,           // Reset, active low
  input wire logic ce,                // Clock enable
  input wire logic spi_sclk,          // Serial clock
  input wire logic spi_cs_n,          // Chip select
  input wire logic spi_miso,          // Serial out
  input wire logic spi_miso_oe,       // Serial out enable
  input wire logic can_txd,           // Transmit in
  input wire logic can_bus_dom,       // Bus dominant
  input wire logic can_drive_dom,     // Drive dominant
  input wire logic can_rxd,           // Receive out
  input wire logic mon_main_uv,       // Regulator low
  input wire logic mon_temp_sd,       // Shutdown temperature
  input wire logic rst_out_n,         // Reset out
  input wire logic main_regulator_off // Regulator off
);
  default clocking cb @(posedge aclk); endclocking
  // A frozen block cannot follow its pins, so no window counts while ce is low
  default disable iff (!aresetn || !ce);
  // Pin windows allow for the two synchroniser stages plus the output flop
  a_tx_dominant: assert property (!can_txd [*6] |-> can_drive_dom)
    else $error("bus not driven dominant");
  a_rx_dominant: assert property (can_bus_dom [*6] |-> !can_rxd)
    else $error("receive output not low");
  a_uv_reset: assert property (mon_main_uv [*4] |-> !rst_out_n)
    else $error("reset not forced by undervoltage");
  a_reset_hold: assert property ($rose(aresetn) |-> !rst_out_n [*8])
    else $error("reset released too early");
  a_miso_off: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("serial out driven while deselected");
  a_miso_on: assert property (!spi_cs_n [*4] |-> spi_miso_oe)
    else $error("serial out not driven while selected");
  a_miso_hold: assert property ((!spi_cs_n && !spi_sclk) [*8] |-> $stable(spi_miso))
    else $error("serial out moved away from a rising edge");
  a_reg_shutdown: assert property (mon_temp_sd [*4] |-> main_regulator_off)
    else $error("regulator not shut off");
endmodule
`default_nettype wire

// ===== scs_mcu_model.sv
// Microcontroller model: serial port master and CAN transmit source
`timescale 1ns/1ps
`default_nettype none
module scs_mcu_model (
  output logic      spi_sclk,   // Serial clock, still low between frames
  output logic      spi_mosi,   // Serial data to device
  output logic      spi_cs_n,   // Chip select, active low
  output logic      can_txd,    // CAN transmit level
  input  wire logic spi_miso,   // Serial data from device
  input  wire logic spi_miso_oe // Serial data enable
);
  initial begin
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    spi_cs_n = 1'b1;
    can_txd = 1'b1;
  end
  // Sends the top n bits of tx; an undriven reply line reads as unknown
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    // Start off the aclk edge so no pin moves in the time step the synchronisers sample
    #2;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #80 spi_sclk = 1'b1;
      spi_mosi = tx[15 - i];
      #80 spi_sclk = 1'b0;
      rx = {rx[14:0], spi_miso_oe ? spi_miso : 1'bx};
    end
    #80 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #320;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the supply companion control logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, can_bus_dom;
  logic mon_bat_low, mon_sup_warn, mon_sec_low, mon_main_uv, mon_temp_warn, mon_temp_sd, mon_hs_ot;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] level_wake_inputs;
  logic [15:0] rx;
  logic ce = 1'b1;
  logic [3:0] wstrb = 4'h1;
  wire awready, wready, bvalid, arready, rvalid, spi_sclk, spi_mosi, spi_cs_n, spi_miso;
  wire spi_miso_oe, can_txd, can_drive_dom, can_rxd, rst_out_n, int_n, watchdog_fault_output_n;
  wire high_side_switch, main_regulator_off, osc_low_sel;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  realtime t0;
  always #5 aclk = ~aclk;
  // Only the longest watchdog period is used in Normal and Standby, so only it is shortened
  scs_ctrl #(.NREQ_CYC(200), .RST_CYC(50), .WD_P3(400), .HS_PER(100), .HS_ON(20))
    u_scs_ctrl (.*);
  scs_mcu_model u_scs_mcu_model (.*);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, can_bus_dom, awaddr, araddr} = '0;
    {mon_bat_low, mon_sup_warn, mon_sec_low, mon_main_uv, mon_temp_warn, mon_temp_sd} = '0;
    {mon_hs_ot, wdata, level_wake_inputs} = '0;
    cyc(6);
    aresetn <= 1'b1;
    cyc(2);
    chk("rst_early", rst_out_n, 1'b0);
    cyc(60);
    chk("rst_late", rst_out_n, 1'b1);
    rd(12'h014, 32'h0000_0001, 2'b00);
    $display("test reset done");
    wr(12'h004, 32'h0000_0003, 2'b00);
    rd(12'h014, 32'h0000_0002, 2'b00);
    wr(12'h020, 32'h0000_0001, 2'b10);
    rd(12'h018, 32'h0000_0000, 2'b10);
    $display("test modes done");
    for (int i = 0; i < 4; i++) begin
      u_scs_mcu_model.can_txd <= i[0];
      can_bus_dom <= i[1];
      cyc(8);
      chk("drive_dom", can_drive_dom, !i[0]);
      chk("rxd", can_rxd, !i[1]);
    end
    ce <= 1'b0;
    can_bus_dom <= 1'b0;
    cyc(8);
    chk("ce_frozen", can_rxd, 1'b0);
    ce <= 1'b1;
    cyc(8);
    chk("ce_run", can_rxd, 1'b1);
    $display("test can done");
    {mon_bat_low, mon_sup_warn, mon_sec_low, mon_hs_ot, mon_temp_warn, mon_temp_sd} <= '1;
    level_wake_inputs <= 4'ha;
    cyc(8);
    rd(12'h010, 32'h0000_00af, 2'b00);
    rd(12'h00c, 32'h0000_0007, 2'b00);
    rd(12'h014, 32'h0000_001a, 2'b00);
    chk("int_masked", int_n, 1'b1);
    wr(12'h008, 32'h0000_0002, 2'b00);
    cyc(4);
    chk("int_set", int_n, 1'b0);
    {mon_bat_low, mon_sup_warn, mon_sec_low, mon_hs_ot, mon_temp_warn, mon_temp_sd} <= '0;
    cyc(8);
    chk("int_held", int_n, 1'b0);
    wr(12'h00c, 32'h0000_0007, 2'b00);
    wr(12'h010, 32'h0000_0008, 2'b00);
    cyc(4);
    chk("int_clear", int_n, 1'b1);
    wr(12'h014, 32'h0000_0001, 2'b00);
    cyc(4);
    chk("hs_on", high_side_switch, 1'b1);
    wr(12'h000, 32'h0000_0003, 2'b00);
    rd(12'h014, 32'h0000_0003, 2'b00);
    wr(12'h000, 32'h0000_0002, 2'b00);
    $display("test flags done");
    wr(12'h004, 32'h0000_0003, 2'b00);
    u_scs_mcu_model.xfer(16'h4000, 16, rx);
    chk("miso", rx, 16'ha002);
    wr(12'h004, 32'h0000_0003, 2'b00);
    u_scs_mcu_model.xfer(16'ha005, 16, rx);
    rd(12'h008, 32'h0000_0005, 2'b00);
    wr(12'h004, 32'h0000_0003, 2'b00);
    u_scs_mcu_model.xfer(16'ha000, 15, rx);
    rd(12'h008, 32'h0000_0005, 2'b00);
    wstrb <= 4'h0;
    wr(12'h008, 32'h0000_0007, 2'b00);
    wstrb <= 4'h1;
    rd(12'h008, 32'h0000_0005, 2'b00);
    $display("test serial done");
    wr(12'h008, 32'h0000_0000, 2'b00);
    wr(12'h000, 32'h0000_0004, 2'b00);
    cyc(6);
    chk("osc_low", osc_low_sel, 1'b1);
    level_wake_inputs <= 4'h5;
    n = 0;
    while (int_n !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    t0 = $realtime;
    rd(12'h014, 32'h0000_0001, 2'b00);
    chk("osc_high", osc_low_sel, 1'b0);
    wr(12'h000, 32'h0000_0002, 2'b00);
    n = 0;
    // Servicing keeps the watchdog quiet while the pulse runs out
    while (int_n === 1'b0 && n < 500) begin
      wr(12'h004, 32'h0000_0003, 2'b00);
      n++;
    end
    n = int'(($realtime - t0) / 10.0);
    chk("pulse", n > 990 && n < 1010, 1'b1);
    $display("test wake done");
    n = 0;
    while (watchdog_fault_output_n !== 1'b0 && n < 600) begin
      cyc(1);
      n++;
    end
    chk("wd_fault", watchdog_fault_output_n, 1'b0);
    chk("wd_rst", rst_out_n, 1'b0);
    cyc(100);
    mon_main_uv <= 1'b1;
    cyc(6);
    chk("uv_rst", rst_out_n, 1'b0);
    $display("test reset causes done");
    give_verdict;
  end
endmodule
bind scs_ctrl scs_ctrl_assertions u_scs_ctrl_assertions (.*);
`default_nettype wire
